//--- logic/src_conv_ctrl.sv
// host data path and control of the sampling rate converter
//
// Operation
// R1 - input flag set when input occupancy at or below 0, 2, 4 or 6.
// R2 - output flag set when output occupancy reaches 1, 4, 8 or 12.
// R3 - input enable bit gates the input fifo interrupt request.
// R4 - output enable bit gates the output fifo interrupt request.
// R5 - channel swap bit exchanges left and right of converted output.
// R6 - input interrupt uses vector 50, output interrupt vector 51.
// R7 - host programs rates and byte orders before starting conversion.
// R8 - each word written to input data enters the input fifo; the code drops a word written while the input fifo is full.
// R9 - each read of output data returns the next converted word.
// R10 - stop flushes pending samples; host drains output afterwards.
// R11 - host can poll a flag saying flush has finished.
// R12 - host order: init, start, stream, stop and flush, release.
// R13 - input rate codes 0,1,2,4,6,8,9,10 mean 8k to 48k.
// R14 - request high while flag and enable set; flags track every clock.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module src_conv_ctrl
  import src_pkg::*;
(
  // clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              SYS_RST_IN,
  // register port
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [DATA_W-1:0] WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [DATA_W-1:0] RDATA_OUT,
  // interrupts
  output logic                   IRQ_OUT,
  output logic                   INPUT_IRQ_OUT,
  output logic                   OUTPUT_IRQ_OUT,
  output logic      [7:0]        IRQ_VECTOR_OUT
);

  in_ctrl_t              in_ctrl_reg;
  out_ctrl_t             out_ctrl_reg;
  conv_state_t           state_reg;
  logic                  flush_done_reg;
  logic                  in_flag_reg;
  logic                  out_flag_reg;
  logic                  in_irq_reg;
  logic                  out_irq_reg;
  logic                  irq_reg;
  logic [7:0]            vector_reg;
  logic [EV_W-1:0]       irq_status_reg;
  logic [EV_W-1:0]       irq_enable_reg;
  logic [DATA_W-1:0]     rdata_reg;

  logic                  in_full;
  logic                  in_empty;
  logic                  out_full;
  logic                  out_empty;
  logic [IN_CNT_W-1:0]   in_count;
  logic [OUT_CNT_W-1:0]  out_count;
  logic [DATA_W-1:0]     in_word;
  logic [DATA_W-1:0]     out_rdata;
  logic [DATA_W-1:0]     sample;
  logic [DATA_W-1:0]     swapped;
  logic [DATA_W-1:0]     out_wdata;
  logic [IN_CNT_W-1:0]   in_level;
  logic [OUT_CNT_W-1:0]  out_level;
  logic                  in_flag_next;
  logic                  out_flag_next;
  logic                  in_irq_next;
  logic                  out_irq_next;
  logic                  wr_in_data;
  logic                  rd_out_data;
  logic                  in_push;
  logic                  out_pop;
  logic                  conv_move;
  logic                  start_req;
  logic                  stop_req;
  logic                  rate_ok;
  logic                  flush_end;
  logic [EV_W-1:0]       events;
  logic [EV_W-1:0]       irq_status_next;

  // register port decode
  assign wr_in_data  = WR_IN && (ADDR_IN == OFS_IN_DATA);
  assign rd_out_data = RD_IN && (ADDR_IN == OFS_OUT_DATA);
  assign in_push     = wr_in_data && !in_full;                                 // [R8]
  assign out_pop     = rd_out_data && !out_empty;                              // [R9]
  assign start_req   = WR_IN && (ADDR_IN == OFS_CONTROL) && WDATA_IN[CTRL_START_BIT];
  assign stop_req    = WR_IN && (ADDR_IN == OFS_CONTROL) && WDATA_IN[CTRL_STOP_BIT];

  // legal input rate codes
  always_comb begin
    unique case (in_ctrl_reg.rate)
      RATE_8K, RATE_11K, RATE_12K, RATE_16K,
      RATE_24K, RATE_32K, RATE_44K, RATE_48K: rate_ok = 1'b1;                 // [R13]
      default:                                rate_ok = 1'b0;
    endcase
  end

  // converter moves one word per cycle while active
  assign conv_move = (state_reg != ST_IDLE) && !in_empty && !out_full;
  assign flush_end = (state_reg == ST_FLUSH) && in_empty;                      // [R10]

  // byte order, channel order and output byte order
  assign sample    = in_ctrl_reg.big_endian
                     ? {in_word[23:16], in_word[31:24], in_word[7:0], in_word[15:8]} : in_word;
  assign swapped   = out_ctrl_reg.channel_swap ? {sample[15:0], sample[31:16]} : sample;   // [R5]
  assign out_wdata = out_ctrl_reg.big_endian
                     ? {swapped[23:16], swapped[31:24], swapped[7:0], swapped[15:8]} : swapped;

  src_fifo #(
    .DATA_W (DATA_W),
    .DEPTH  (IN_DEPTH),
    .PTR_W  (IN_PTR_W),
    .CNT_W  (IN_CNT_W)
  ) u_in_fifo (
    .clk_in    (CLK_IN),
    .rst_in    (SYS_RST_IN),
    .push_in   (in_push),
    .wdata_in  (WDATA_IN),
    .pop_in    (conv_move),
    .rdata_out (in_word),
    .count_out (in_count),
    .full_out  (in_full),
    .empty_out (in_empty)
  );

  src_fifo #(
    .DATA_W (DATA_W),
    .DEPTH  (OUT_DEPTH),
    .PTR_W  (OUT_PTR_W),
    .CNT_W  (OUT_CNT_W)
  ) u_out_fifo (
    .clk_in    (CLK_IN),
    .rst_in    (SYS_RST_IN),
    .push_in   (conv_move),
    .wdata_in  (out_wdata),
    .pop_in    (out_pop),
    .rdata_out (out_rdata),
    .count_out (out_count),
    .full_out  (out_full),
    .empty_out (out_empty)
  );

  // trigger level lookup
  always_comb begin
    unique case (in_ctrl_reg.trigger)
      2'h0: in_level = IN_LEVEL_0;
      2'h1: in_level = IN_LEVEL_1;
      2'h2: in_level = IN_LEVEL_2;
      2'h3: in_level = IN_LEVEL_3;
    endcase
    unique case (out_ctrl_reg.trigger)
      2'h0: out_level = OUT_LEVEL_0;
      2'h1: out_level = OUT_LEVEL_1;
      2'h2: out_level = OUT_LEVEL_2;
      2'h3: out_level = OUT_LEVEL_3;
    endcase
  end

  assign in_flag_next  = (in_count <= in_level);                               // [R1]
  assign out_flag_next = (out_count >= out_level);                             // [R2]
  assign in_irq_next   = in_flag_reg && in_ctrl_reg.irq_enable;                // [R3] [R14]
  assign out_irq_next  = out_flag_reg && out_ctrl_reg.irq_enable;              // [R4] [R14]

  // threshold flags and gated requests
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      // empty fifo meets every input level, so no false rise after reset
      in_flag_reg  <= 1'b1;
      out_flag_reg <= 1'b0;
      in_irq_reg   <= 1'b0;
      out_irq_reg  <= 1'b0;
      vector_reg   <= VEC_NONE;
    end else begin
      in_flag_reg  <= in_flag_next;                                            // [R14]
      out_flag_reg <= out_flag_next;
      in_irq_reg   <= in_irq_next;
      out_irq_reg  <= out_irq_next;
      vector_reg   <= in_irq_next ? VEC_INPUT : (out_irq_next ? VEC_OUTPUT : VEC_NONE);  // [R6]
    end
  end

  // setup only while idle so rates and byte orders stay fixed in a stream
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      in_ctrl_reg  <= IN_CTRL_RST;
      out_ctrl_reg <= OUT_CTRL_RST;
    end else if (WR_IN && state_reg == ST_IDLE) begin                          // [R7]
      if (ADDR_IN == OFS_IN_CTRL) begin
        in_ctrl_reg <= in_ctrl_t'(WDATA_IN[7:0]);
      end
      if (ADDR_IN == OFS_OUT_CTRL) begin
        out_ctrl_reg <= out_ctrl_t'(WDATA_IN[8:0]);
      end
    end
  end

  // conversion sequence
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      state_reg      <= ST_IDLE;
      flush_done_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_req && rate_ok) begin                                      // [R13]
            state_reg      <= ST_RUN;
            flush_done_reg <= 1'b0;
          end
        end
        ST_RUN: begin
          if (stop_req) begin                                                  // [R10]
            state_reg <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          if (flush_end) begin
            state_reg      <= ST_IDLE;
            flush_done_reg <= 1'b1;                                            // [R11]
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // sticky events, set wins over clear
  assign events[EV_IN_THRESH]  = in_flag_next && !in_flag_reg;
  assign events[EV_OUT_THRESH] = out_flag_next && !out_flag_reg;
  assign events[EV_FLUSHED]    = flush_end;
  assign events[EV_OVERFLOW]   = wr_in_data && in_full;
  assign events[EV_UNDERFLOW]  = rd_out_data && out_empty;
  assign events[EV_RATE_ERR]   = start_req && (state_reg == ST_IDLE) && !rate_ok;

  always_comb begin
    irq_status_next = irq_status_reg;
    if (WR_IN && ADDR_IN == OFS_IRQ_CLEAR) begin
      irq_status_next = irq_status_next & ~WDATA_IN[EV_W-1:0];
    end
    irq_status_next = irq_status_next | events;
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      irq_status_reg <= EV_RST;
      irq_enable_reg <= EV_RST;
      irq_reg        <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (WR_IN && ADDR_IN == OFS_IRQ_ENABLE) begin
        irq_enable_reg <= WDATA_IN[EV_W-1:0];
      end
      irq_reg <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // read data, valid the cycle after the strobe
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      rdata_reg <= '0;
    end else if (RD_IN) begin
      rdata_reg <= '0;
      unique case (ADDR_IN)
        OFS_IN_CTRL:    rdata_reg[7:0] <= in_ctrl_reg;
        OFS_OUT_CTRL:   rdata_reg[8:0] <= out_ctrl_reg;
        OFS_STATUS: begin
          rdata_reg[ST_IN_FLAG_BIT]                        <= in_flag_reg;
          rdata_reg[ST_OUT_FLAG_BIT]                       <= out_flag_reg;
          rdata_reg[ST_FLUSHED_BIT]                        <= flush_done_reg;   // [R11]
          rdata_reg[ST_RUNNING_BIT]                        <= (state_reg != ST_IDLE);
          rdata_reg[ST_IN_CNT_LSB +: IN_CNT_W]             <= in_count;
          rdata_reg[ST_OUT_CNT_LSB +: OUT_CNT_W]           <= out_count;
        end
        OFS_OUT_DATA:   rdata_reg <= out_empty ? '0 : out_rdata;               // [R9]
        OFS_IRQ_STATUS: rdata_reg[EV_W-1:0] <= irq_status_reg;
        OFS_IRQ_ENABLE: rdata_reg[EV_W-1:0] <= irq_enable_reg;
        default:        rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign RDATA_OUT      = rdata_reg;
  assign IRQ_OUT        = irq_reg;
  assign INPUT_IRQ_OUT  = in_irq_reg;
  assign OUTPUT_IRQ_OUT = out_irq_reg;
  assign IRQ_VECTOR_OUT = vector_reg;

  // checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  sequence flush_drained_s;
    (state_reg == ST_FLUSH) && in_empty;
  endsequence

  sequence back_idle_s;
    (state_reg == ST_IDLE) && flush_done_reg;
  endsequence

  a_in_thresh_flag: assert property (in_flag_reg == $past(in_count <= in_level))   // [R1]
    else $error("input threshold flag wrong");
  a_out_thresh_flag: assert property (out_flag_reg == $past(out_count >= out_level))  // [R2]
    else $error("output threshold flag wrong");
  a_in_irq_gate: assert property (INPUT_IRQ_OUT |-> $past(in_flag_reg && in_ctrl_reg.irq_enable))  // [R3]
    else $error("input request without flag and enable");
  a_out_irq_gate: assert property ((out_flag_reg && out_ctrl_reg.irq_enable) |=> OUTPUT_IRQ_OUT)  // [R4]
    else $error("output request missing");
  a_swap_order: assert property ((conv_move && out_ctrl_reg.channel_swap) |-> out_wdata[31:16]
                                 == (out_ctrl_reg.big_endian ? {sample[7:0], sample[15:8]} : sample[15:0]))  // [R5]
    else $error("channel order wrong");
  a_vector_code: assert property (INPUT_IRQ_OUT |-> IRQ_VECTOR_OUT == VEC_INPUT)   // [R6]
    else $error("input vector wrong");
  a_write_accept: assert property ((wr_in_data && !in_full && !conv_move)
                                   |=> in_count == $past(in_count) + IN_CNT_W'(1))  // [R8]
    else $error("input word not taken");
  a_read_next: assert property (out_pop |=> RDATA_OUT == $past(out_rdata))          // [R9]
    else $error("read data not next word");
  a_flush_finish: assert property (flush_drained_s |=> back_idle_s ##1
                                   (flush_done_reg || state_reg == ST_RUN))  // [R10] [R11]
    else $error("flush did not finish");
  a_rate_reject: assert property ((start_req && state_reg == ST_IDLE && !rate_ok) |=> state_reg == ST_IDLE)  // [R13]
    else $error("start with illegal rate");
  a_stop_sequence: assert property ((state_reg == ST_RUN && stop_req) |=> state_reg == ST_FLUSH)  // [R10]
    else $error("stop did not flush");

endmodule : src_conv_ctrl
`default_nettype wire

//--- logic/src_fifo.sv
// sample fifo built from flip-flops with occupancy count
`timescale 1ns/1ns
`default_nettype none
module src_fifo #(
  parameter int DATA_W = 32,
  parameter int DEPTH  = 8,
  parameter int PTR_W  = 3,
  parameter int CNT_W  = 4
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // fill side
  input  wire logic              push_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  // drain side
  input  wire logic              pop_in,
  output logic      [DATA_W-1:0] rdata_out,
  // state
  output logic      [CNT_W-1:0]  count_out,
  output logic                   full_out,
  output logic                   empty_out
);

  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0]  wr_ptr_reg;
  logic [PTR_W-1:0]  rd_ptr_reg;
  logic [CNT_W-1:0]  count_reg;
  logic              do_push;
  logic              do_pop;

  assign do_push   = push_in && !full_out;
  assign do_pop    = pop_in && !empty_out;
  assign full_out  = (count_reg == CNT_W'(DEPTH));
  assign empty_out = (count_reg == '0);
  assign count_out = count_reg;
  assign rdata_out = mem_reg[rd_ptr_reg];

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_in) begin
      if (do_push && wr_ptr_reg == PTR_W'(i)) begin
        mem_reg[i] <= wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + CNT_W'(1);
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - CNT_W'(1);
      end
    end
  end

endmodule : src_fifo
`default_nettype wire

//--- shared/src_pkg.sv
// constants, types and register layout of the rate converter data path
`default_nettype none
package src_pkg;

  // data path sizes
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 8;
  localparam int IN_DEPTH   = 8;
  localparam int OUT_DEPTH  = 16;
  localparam int IN_PTR_W   = 3;
  localparam int OUT_PTR_W  = 4;
  localparam int IN_CNT_W   = 4;
  localparam int OUT_CNT_W  = 5;
  localparam int EV_W       = 6;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_IN_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_CTRL   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CONTROL    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IN_DATA    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OUT_DATA   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h20;

  // control register bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT  = 1;

  // status register fields
  localparam int ST_IN_FLAG_BIT  = 0;
  localparam int ST_OUT_FLAG_BIT = 1;
  localparam int ST_FLUSHED_BIT  = 2;
  localparam int ST_RUNNING_BIT  = 3;
  localparam int ST_IN_CNT_LSB   = 4;
  localparam int ST_OUT_CNT_LSB  = 8;

  // sticky event bits
  localparam int EV_IN_THRESH  = 0;
  localparam int EV_OUT_THRESH = 1;
  localparam int EV_FLUSHED    = 2;
  localparam int EV_OVERFLOW   = 3;
  localparam int EV_UNDERFLOW  = 4;
  localparam int EV_RATE_ERR   = 5;

  // interrupt vector numbers
  localparam logic [7:0] VEC_INPUT  = 8'h32;
  localparam logic [7:0] VEC_OUTPUT = 8'h33;
  localparam logic [7:0] VEC_NONE   = 8'h00;

  // trigger levels per 2-bit code
  localparam logic [IN_CNT_W-1:0]  IN_LEVEL_0  = 4'h0;
  localparam logic [IN_CNT_W-1:0]  IN_LEVEL_1  = 4'h2;
  localparam logic [IN_CNT_W-1:0]  IN_LEVEL_2  = 4'h4;
  localparam logic [IN_CNT_W-1:0]  IN_LEVEL_3  = 4'h6;
  localparam logic [OUT_CNT_W-1:0] OUT_LEVEL_0 = 5'h01;
  localparam logic [OUT_CNT_W-1:0] OUT_LEVEL_1 = 5'h04;
  localparam logic [OUT_CNT_W-1:0] OUT_LEVEL_2 = 5'h08;
  localparam logic [OUT_CNT_W-1:0] OUT_LEVEL_3 = 5'h0C;

  // input sampling rate codes
  typedef enum logic [3:0] {
    RATE_8K    = 4'h0,
    RATE_11K   = 4'h1,
    RATE_12K   = 4'h2,
    RATE_16K   = 4'h4,
    RATE_24K   = 4'h6,
    RATE_32K   = 4'h8,
    RATE_44K   = 4'h9,
    RATE_48K   = 4'hA
  } rate_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_FLUSH = 2'b10
  } conv_state_t;

  // bits [7:0] of the input control register
  typedef struct packed {
    logic       big_endian;
    logic [3:0] rate;
    logic [1:0] trigger;
    logic       irq_enable;
  } in_ctrl_t;

  // bits [8:0] of the output control register
  typedef struct packed {
    logic       channel_swap;
    logic       big_endian;
    logic [3:0] rate;
    logic [1:0] trigger;
    logic       irq_enable;
  } out_ctrl_t;

  // reset values
  localparam in_ctrl_t  IN_CTRL_RST  = '{big_endian: 1'b0, rate: 4'h0, trigger: 2'h3, irq_enable: 1'b0};
  localparam out_ctrl_t OUT_CTRL_RST = '{channel_swap: 1'b0, big_endian: 1'b0, rate: 4'h0,
                                         trigger: 2'h3, irq_enable: 1'b0};
  localparam logic [EV_W-1:0] EV_RST = 6'h00;

endpackage : src_pkg
`default_nettype wire

//--- testbench/host_bus_model.sv
// host bus master model driving the converter register port
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
  import src_pkg::*;
(
  // clock
  input  wire logic              clk_in,
  // register port
  output logic      [ADDR_W-1:0] addr_out,
  output logic      [DATA_W-1:0] wdata_out,
  output logic                   wr_out,
  output logic                   rd_out,
  input  wire logic [DATA_W-1:0] rdata_in
);
  initial begin
    addr_out  = '0;
    wdata_out = '0;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // one-cycle write; rates set and words fed through here
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= v;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~v;
  endtask : write_reg

  // data taken in the cycle after the strobe; drains output
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 v = rdata_in;
  endtask : read_reg
endmodule : host_bus_model
`default_nettype wire

//--- testbench/sample_rate_converter_fifo_ctrl_test.sv
// self-checking bench for the converter host data path
`timescale 1ns/1ns
`default_nettype none
module sample_rate_converter_fifo_ctrl_test
  import src_pkg::*;
;
  logic              clk;
  logic              rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic              in_irq;
  logic              out_irq;
  logic [7:0]        vec;
  logic [DATA_W-1:0] d;
  int                fail_count;
  int                n_checks;

  src_conv_ctrl i_src_conv_ctrl (
    .CLK_IN         (clk),
    .SYS_RST_IN     (rst),
    .ADDR_IN        (addr),
    .WDATA_IN       (wdata),
    .WR_IN          (wr),
    .RD_IN          (rd),
    .RDATA_OUT      (rdata),
    .IRQ_OUT        (irq),
    .INPUT_IRQ_OUT  (in_irq),
    .OUTPUT_IRQ_OUT (out_irq),
    .IRQ_VECTOR_OUT (vec)
  );

  host_bus_model i_host_bus_model (
    .clk_in    (clk),
    .addr_out  (addr),
    .wdata_out (wdata),
    .wr_out    (wr),
    .rd_out    (rd),
    .rdata_in  (rdata)
  );

  function automatic logic [31:0] word(input int i);
    return {8'hA0, 8'(i), 8'h50, 8'(i)};
  endfunction : word

  function automatic logic [31:0] swapped(input int i);
    return {8'h50, 8'(i), 8'hA0, 8'(i)};
  endfunction : swapped

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic reg_w(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    i_host_bus_model.write_reg(a, v);
  endtask : reg_w

  task automatic reg_r(input logic [ADDR_W-1:0] a);
    i_host_bus_model.read_reg(a, d);
  endtask : reg_r

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // bounded poll of one status bit
  task automatic wait_status(input int pos, input logic val);
    for (int i = 0; i < 64; i++) begin
      reg_r(OFS_STATUS);
      if (d[pos] === val) return;
    end
    fail_count++;
    $display("ERROR status wait expected %b seen %b", val, d[pos]);
    final_report();
  endtask : wait_status

  task automatic test_reset();
    reg_r(OFS_IN_CTRL);
    chk("in ctrl reset", 32'h0000_0006, d);
    reg_r(OFS_OUT_CTRL);
    chk("out ctrl reset", 32'h0000_0006, d);
    reg_r(OFS_STATUS);
    chk("status reset", 32'h0000_0001, d);
    reg_r(8'h3C);
    chk("unmapped read", 32'h0, d);
    reg_r(OFS_IRQ_STATUS);
    chk("events reset", 32'h0, d);
    chk("irq lines reset", 32'h0, {21'h0, in_irq, out_irq, irq, vec});
    $display("test reset done");
  endtask : test_reset

  task automatic test_input_level();
    int lvl[4] = '{0, 2, 4, 6};
    for (int n = 0; n <= 8; n++) begin
      for (int c = 0; c < 4; c++) begin
        reg_w(OFS_IN_CTRL, {29'h0, 2'(c), 1'b0});
        reg_r(OFS_STATUS);
        chk("in flag", 32'(n <= lvl[c]), 32'(d[ST_IN_FLAG_BIT]));
      end
      chk("in count", 32'(n), 32'(d[7:4]));
      reg_w(OFS_IN_DATA, word(n));
    end
    reg_r(OFS_STATUS);
    chk("full count", 32'h8, 32'(d[7:4]));
    reg_r(OFS_IRQ_STATUS);
    chk("overflow event", 32'h1, 32'(d[EV_OVERFLOW]));
    chk("in level event", 32'h1, 32'(d[EV_IN_THRESH]));
    reg_w(OFS_IRQ_ENABLE, 32'h0000_0008);
    settle();
    chk("irq set", 32'h1, 32'(irq));
    reg_w(OFS_IRQ_CLEAR, 32'h0000_0008);
    settle();
    chk("irq clear", 32'h0, 32'(irq));
    reg_w(OFS_IRQ_ENABLE, 32'h0);
    $display("test input level done");
  endtask : test_input_level

  task automatic test_convert();
    int lvl[4] = '{1, 4, 8, 12};
    reg_w(OFS_OUT_CTRL, 32'h0000_0107);
    reg_w(OFS_CONTROL, 32'h1);
    reg_w(OFS_CONTROL, 32'h2);
    wait_status(ST_FLUSHED_BIT, 1'b1);
    chk("stopped", 32'h0, 32'(d[ST_RUNNING_BIT]));
    chk("out count", 32'h8, 32'(d[12:8]));
    for (int k = 8; k >= 0; k--) begin
      for (int c = 0; c < 4; c++) begin
        reg_w(OFS_OUT_CTRL, {23'h0, 1'b1, 5'h0, 2'(c), 1'b1});
        reg_r(OFS_STATUS);
        settle();
        chk("out flag", 32'(k >= lvl[c]), 32'(d[ST_OUT_FLAG_BIT]));
        chk("out irq", 32'(k >= lvl[c]), 32'(out_irq));
        chk("out vector", (k >= lvl[c]) ? 32'h33 : 32'h0, 32'(vec));
      end
      reg_r(OFS_OUT_DATA);
      chk("out word", (k > 0) ? swapped(8 - k) : 32'h0, d);
    end
    reg_r(OFS_IRQ_STATUS);
    chk("underflow event", 32'h1, 32'(d[EV_UNDERFLOW]));
    chk("flush event", 32'h1, 32'(d[EV_FLUSHED]));
    chk("out level event", 32'h1, 32'(d[EV_OUT_THRESH]));
    reg_w(OFS_OUT_CTRL, 32'h0000_0006);
    reg_w(OFS_CONTROL, 32'h1);
    reg_w(OFS_OUT_CTRL, 32'h0000_0107);
    reg_w(OFS_IN_DATA, word(9));
    reg_w(OFS_CONTROL, 32'h2);
    wait_status(ST_FLUSHED_BIT, 1'b1);
    reg_r(OFS_OUT_DATA);
    chk("unswapped word", word(9), d);
    $display("test convert done");
  endtask : test_convert

  task automatic test_rates();
    logic ok;
    for (int r = 0; r <= 10; r++) begin
      ok = r inside {0, 1, 2, 4, 6, 8, 9, 10};
      reg_w(OFS_IN_CTRL, {25'h0, 4'(r), 2'h3, 1'b1});
      settle();
      chk("in irq", 32'h1, 32'(in_irq));
      chk("in vector", 32'h32, 32'(vec));
      reg_w(OFS_CONTROL, 32'h1);
      reg_r(OFS_STATUS);
      chk("running", 32'(ok), 32'(d[ST_RUNNING_BIT]));
      if (ok) begin
        reg_w(OFS_CONTROL, 32'h2);
        wait_status(ST_FLUSHED_BIT, 1'b1);
      end
    end
    reg_r(OFS_IRQ_STATUS);
    chk("rate error event", 32'h1, 32'(d[EV_RATE_ERR]));
    reg_w(OFS_IN_CTRL, 32'h0000_0006);
    settle();
    chk("in irq masked", 32'h0, 32'(in_irq));
    $display("test rates done");
  endtask : test_rates

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    fail_count = 0;
    n_checks   = 0;
    rst        = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_input_level();
    test_convert();
    test_rates();
    final_report();
  end
endmodule : sample_rate_converter_fifo_ctrl_test
`default_nettype wire
